// file: hw/bdp_map.svh
// register offsets, field positions, reset values and timing of the data port
//Contract
//- two ports, CMOS or LVDS, selectable ordering
//- TDD shares ports; FDD splits tx/rx bits
//- single-port configuration uses port a only
//- drive rx clock, data out of phase
//- rx clock SDR or DDR, any port count
//- controls on return rising; data SDR/DDR edges
//- rx frame level or 50% pulse mode
//- six states: wait sleep tx rx fdd alert
//- control by register writes or pins
//- register writes advance state, clock independent
//- pins govern state, TDD/FDD by config
//- enable pin advances by pulse or level
//- level mode still edge detects both pins
//- FDD remap: pins become rx/tx path on
//- remapped: state by registers, pins gate data
//- clocks and framing come from baseband synth
`ifndef BDP_MAP_SVH
`define BDP_MAP_SVH

`define BDP_OFS_CONFIG     12'h000
`define BDP_OFS_STATE_CMD  12'h004
`define BDP_OFS_STATUS     12'h008

`define BDP_CFG_W          10
`define BDP_CFG_RESET      10'h000

`define BDP_STS_STATE_LSB  0
`define BDP_STS_SYNTH      3
`define BDP_STS_RX_PATH    4
`define BDP_STS_TX_PATH    5
`define BDP_STS_RX_BUSY    6

// rx clock is pclk divided by four; phase 0,1 high and 2,3 low
`define BDP_PH_SDR_TICK    2'h1
`define BDP_PH_HIGH_END    2'h2

`define BDP_OE_ALL         12'hfff
`define BDP_OE_HALF        12'h03f

`endif

// file: hw/bdp_pkg.sv
// shared types of the baseband data port
package bdp_pkg;

   typedef enum logic [2:0] {
      BDP_WAIT  = 3'b000,
      BDP_SLEEP = 3'b001,
      BDP_TX    = 3'b010,
      BDP_RX    = 3'b011,
      BDP_FDD   = 3'b100,
      BDP_ALERT = 3'b101
   } bdp_state_t;

   // bit 0 is lvds, bit 9 is remap
   typedef struct packed {
      logic remap;
      logic pin_pulse;
      logic pin_ctrl;
      logic order_swap;
      logic tx_frame_pulse;
      logic rx_frame_pulse;
      logic ddr;
      logic single_port;
      logic fdd;
      logic lvds;
   } bdp_cfg_t;

endpackage

// file: hw/bdp_enable_state_machine_if.sv
// signals between the port logic and the enable state machine
`timescale 1ns/1ps
`default_nettype none

interface bdp_enable_state_machine_if;
   logic                 cmd_valid;
   bdp_pkg::bdp_state_t  cmd_state;
   bdp_pkg::bdp_cfg_t    cfg;
   logic                 en_rise;
   logic                 en_fall;
   logic                 dir_level;
   logic                 dir_edge;
   bdp_pkg::bdp_state_t  state;

   modport ctrl (output cmd_valid, output cmd_state, output cfg,
                 output en_rise, output en_fall, output dir_level,
                 output dir_edge, input state);
   modport fsm  (input cmd_valid, input cmd_state, input cfg,
                 input en_rise, input en_fall, input dir_level,
                 input dir_edge, output state);
endinterface

`default_nettype wire

// file: hw/bdp_enable_state_machine.sv
// enable state machine of the transceiver
`timescale 1ns/1ps
`default_nettype none

module bdp_enable_state_machine
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   bdp_enable_state_machine_if.fsm    ctl
);

   typedef struct packed {
      bdp_pkg::bdp_state_t state;
   } bdp_enable_state_machine_st_t;

   bdp_enable_state_machine_st_t s;
   bdp_enable_state_machine_st_t next_s;
   logic         active;
   logic         pins_rule;
   logic         cmd_legal;

   assign ctl.state = s.state;

   always_comb
   begin
      next_s    = s;
      active    = (s.state == bdp_pkg::BDP_TX) || (s.state == bdp_pkg::BDP_RX)
                  || (s.state == bdp_pkg::BDP_FDD);
      // remapped pins only gate data, never the state
      pins_rule = ctl.cfg.pin_ctrl && !(ctl.cfg.remap && ctl.cfg.fdd);
      cmd_legal = 1'b0;
      case (ctl.cmd_state)
         bdp_pkg::BDP_WAIT, bdp_pkg::BDP_SLEEP, bdp_pkg::BDP_ALERT:
            cmd_legal = 1'b1;
         bdp_pkg::BDP_TX, bdp_pkg::BDP_RX:
            cmd_legal = !pins_rule && !ctl.cfg.fdd;
         bdp_pkg::BDP_FDD:
            cmd_legal = !pins_rule && ctl.cfg.fdd;
         default:
            cmd_legal = 1'b0;
      endcase
      if (ctl.cmd_valid && cmd_legal)
      begin
         next_s.state = ctl.cmd_state;
      end
      else if (pins_rule)
      begin
         if (ctl.en_rise && s.state == bdp_pkg::BDP_ALERT)
         begin
            if (ctl.cfg.fdd)
               next_s.state = bdp_pkg::BDP_FDD;
            else if (ctl.dir_level)
               next_s.state = bdp_pkg::BDP_TX;
            else
               next_s.state = bdp_pkg::BDP_RX;
         end
         else if (active && ((ctl.cfg.pin_pulse && ctl.en_rise)
                  || (!ctl.cfg.pin_pulse && ctl.en_fall)))
         begin
            next_s.state = bdp_pkg::BDP_ALERT;
         end
         else if (!ctl.cfg.pin_pulse && ctl.dir_edge && !ctl.cfg.fdd
                  && active)
         begin
            // direction changes are edge detected in level mode too
            next_s.state = ctl.dir_level ? bdp_pkg::BDP_TX
                                         : bdp_pkg::BDP_RX;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

endmodule

`default_nettype wire

// file: hw/bdp_tx_capture.sv
// transmit data capture from the return clock domain samples
`timescale 1ns/1ps
`default_nettype none

module bdp_tx_capture
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               ret_rise,
   input  wire logic               ret_fall,
   input  wire logic               frame,
   input  wire logic [11:0]        pins_a,
   input  wire logic [11:0]        pins_b,
   input  wire bdp_pkg::bdp_cfg_t  cfg,
   input  wire logic               tx_active,
   output logic [23:0]             tx_sample_data,
   output logic                    tx_sample_valid
);

   typedef struct packed {
      logic        frame_prev;
      logic        burst;
      logic [1:0]  cnt;
      logic [23:0] acc;
      logic [23:0] data;
      logic        valid;
   } bdp_txc_st_t;

   bdp_txc_st_t s;
   bdp_txc_st_t next_s;
   logic        cap;
   logic        start;
   logic [1:0]  last;
   logic [23:0] acc_n;

   assign tx_sample_data  = s.data;
   assign tx_sample_valid = s.valid;

   always_comb
   begin
      next_s       = s;
      next_s.valid = 1'b0;
      // data on rising only in SDR, both edges in DDR
      cap   = ret_rise || (cfg.ddr && ret_fall);
      start = ret_rise && frame && !s.frame_prev;
      last  = (!cfg.single_port && !cfg.fdd) ? 2'h0
            : (cfg.single_port && cfg.fdd) ? 2'h3 : 2'h1;
      case (last)
         2'h0:    acc_n = {pins_b, pins_a};
         2'h3:    acc_n = {pins_a[11:6], s.acc[23:6]};
         default: acc_n = {(cfg.single_port ? pins_a : pins_b), s.acc[23:12]};
      endcase
      if (ret_rise)
         next_s.frame_prev = frame;
      if (!tx_active)
      begin
         next_s.burst = 1'b0;
         next_s.cnt   = 2'h0;
      end
      else if (cap && (start || s.burst))
      begin
         if (s.burst && ret_rise && !cfg.tx_frame_pulse && !frame)
         begin
            next_s.burst = 1'b0;
            next_s.cnt   = 2'h0;
         end
         else
         begin
            next_s.burst = 1'b1;
            next_s.acc   = acc_n;
            // each frame rise realigns to the first beat of a sample
            if ((start ? 2'h0 : s.cnt) == last)
            begin
               next_s.cnt   = 2'h0;
               next_s.valid = 1'b1;
               next_s.data  = cfg.order_swap ? {acc_n[11:0], acc_n[23:12]}
                                             : acc_n;
            end
            else
               next_s.cnt = start ? 2'h1 : 2'(s.cnt + 2'h1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

endmodule

`default_nettype wire

// file: hw/bdp_data_port.sv
// baseband data port: apb registers, rx serializer, pin front end
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`include "bdp_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bdp_data_port
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [11:0]  paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [23:0]  rx_sample_data,
   input  wire logic         rx_sample_valid,
   output logic              rx_sample_ready,
   output logic [23:0]       tx_sample_data,
   output logic              tx_sample_valid,
   output logic              rx_data_clock,
   output logic              rx_frame,
   input  wire logic [11:0]  data_port_a_in,
   output logic [11:0]       data_port_a_out,
   output logic [11:0]       data_port_a_oe,
   input  wire logic [11:0]  data_port_b_in,
   output logic [11:0]       data_port_b_out,
   output logic [11:0]       data_port_b_oe,
   input  wire logic         tx_return_clock,
   input  wire logic         tx_frame,
   input  wire logic         enable_state_machine,
   input  wire logic         direction_select_pin,
   output logic              lvds_select,
   output logic              bb_synth_on,
   output logic              rx_synth_on,
   output logic              tx_synth_on,
   output logic              rx_chain_on,
   output logic              tx_chain_on,
   output logic [2:0]        enable_state_machine_state
);

   typedef struct packed {
      bdp_pkg::bdp_cfg_t   cfg;
      logic                cmd_valid;
      bdp_pkg::bdp_state_t cmd_state;
      logic [31:0]         rdata;
      logic [27:0]         sy1;
      logic [27:0]         sy2;
      logic                ret_prev;
      logic                en_lat;
      logic                dir_lat;
      logic                en_prev;
      logic                dir_prev;
      logic [1:0]          ph;
      logic                clk;
      logic                busy;
      logic [1:0]          cnt;
      logic                tog;
      logic [23:0]         sh;
      logic [11:0]         a_out;
      logic [11:0]         b_out;
      logic                frame;
   } bdp_st_t;

   bdp_st_t              s;
   bdp_st_t              next_s;
   bdp_pkg::bdp_state_t  state;
   logic                 ret_rise;
   logic                 ret_fall;
   logic                 remap_on;
   logic                 rx_path;
   logic                 tx_path;
   logic                 synth_on;
   logic                 tick;
   logic                 slot_free;
   logic [1:0]           last;
   logic                 mapped;
   logic [23:0]          word;
   logic [23:0]          lanes;

   bdp_enable_state_machine_if ens ();

   // sync layout: 27 return clock, 26 frame, 25 enable, 24 dir, b, a
   assign ret_rise = s.sy2[27] && !s.ret_prev;
   assign ret_fall = !s.sy2[27] && s.ret_prev;
   assign state    = ens.state;
   assign remap_on = s.cfg.remap && s.cfg.fdd;
   assign rx_path  = remap_on ? (state == bdp_pkg::BDP_FDD && s.en_lat)
                     : (state == bdp_pkg::BDP_RX || state == bdp_pkg::BDP_FDD);
   assign tx_path  = remap_on ? (state == bdp_pkg::BDP_FDD && s.dir_lat)
                     : (state == bdp_pkg::BDP_TX || state == bdp_pkg::BDP_FDD);
   // sleep stops the baseband synth and with it every port clock
   assign synth_on = (state != bdp_pkg::BDP_SLEEP);
   assign last     = (!s.cfg.single_port && !s.cfg.fdd) ? 2'h0
                   : (s.cfg.single_port && s.cfg.fdd) ? 2'h3 : 2'h1;
   // data moves half an rx clock period (SDR) or a quarter of one (DDR) away from the sampling edge
   assign tick     = s.cfg.ddr ? (s.ph[0] == 1'b0)
                               : (s.ph == `BDP_PH_SDR_TICK);
   assign slot_free       = tick && rx_path && (!s.busy || s.cnt == last);
   assign rx_sample_ready = slot_free;

   assign ens.cmd_valid = s.cmd_valid;
   assign ens.cmd_state = s.cmd_state;
   assign ens.cfg       = s.cfg;
   assign ens.en_rise   = s.en_lat && !s.en_prev;
   assign ens.en_fall   = !s.en_lat && s.en_prev;
   assign ens.dir_level = s.dir_lat;
   assign ens.dir_edge  = s.dir_lat != s.dir_prev;

   assign pready          = 1'b1;
   assign prdata          = s.rdata;
   assign mapped          = (paddr == `BDP_OFS_CONFIG)
                            || (paddr == `BDP_OFS_STATE_CMD)
                            || (paddr == `BDP_OFS_STATUS);
   assign pslverr         = psel && penable && !mapped;
   assign rx_data_clock   = s.clk;
   assign rx_frame        = s.frame;
   assign data_port_a_out = s.a_out;
   assign data_port_b_out = s.b_out;
   assign data_port_a_oe  = !rx_path ? 12'h000
                          : (s.cfg.single_port && s.cfg.fdd) ? `BDP_OE_HALF
                          : `BDP_OE_ALL;
   assign data_port_b_oe  = (rx_path && !s.cfg.single_port && !s.cfg.fdd)
                          ? `BDP_OE_ALL : 12'h000;
   assign lvds_select     = s.cfg.lvds;
   assign bb_synth_on     = synth_on;
   assign rx_synth_on     = (state == bdp_pkg::BDP_ALERT)
                          || (state == bdp_pkg::BDP_RX)
                          || (state == bdp_pkg::BDP_FDD);
   assign tx_synth_on     = (state == bdp_pkg::BDP_ALERT)
                          || (state == bdp_pkg::BDP_TX)
                          || (state == bdp_pkg::BDP_FDD);
   assign rx_chain_on     = rx_path;
   assign tx_chain_on     = tx_path;
   assign enable_state_machine_state      = state;

   always_comb
   begin
      next_s           = s;
      next_s.cmd_valid = 1'b0;
      word             = 24'h000000;
      lanes            = 24'h000000;

      // apb: write at access phase, read data latched in setup
      if (psel && penable && pwrite)
      begin
         if (paddr == `BDP_OFS_CONFIG)
            next_s.cfg = bdp_pkg::bdp_cfg_t'(pwdata[`BDP_CFG_W-1:0]);
         if (paddr == `BDP_OFS_STATE_CMD)
         begin
            next_s.cmd_valid = 1'b1;
            next_s.cmd_state = bdp_pkg::bdp_state_t'(pwdata[2:0]);
         end
      end
      if (psel && !penable)
      begin
         next_s.rdata = 32'h00000000;
         case (paddr)
            `BDP_OFS_CONFIG:
               next_s.rdata[`BDP_CFG_W-1:0] = s.cfg;
            `BDP_OFS_STATE_CMD:
               next_s.rdata[2:0] = s.cmd_state;
            `BDP_OFS_STATUS:
            begin
               next_s.rdata[`BDP_STS_STATE_LSB+:3] = state;
               next_s.rdata[`BDP_STS_SYNTH]        = synth_on;
               next_s.rdata[`BDP_STS_RX_PATH]      = rx_path;
               next_s.rdata[`BDP_STS_TX_PATH]      = tx_path;
               next_s.rdata[`BDP_STS_RX_BUSY]      = s.busy;
            end
            default:
               next_s.rdata = 32'h00000000;
         endcase
      end

      // pins pass two flops before anything looks at them
      next_s.sy1 = {tx_return_clock, tx_frame, enable_state_machine,
                    direction_select_pin, data_port_b_in, data_port_a_in};
      next_s.sy2      = s.sy1;
      next_s.ret_prev = s.sy2[27];
      next_s.en_prev  = s.en_lat;
      next_s.dir_prev = s.dir_lat;
      if (ret_rise)
      begin
         next_s.en_lat  = s.sy2[25];
         next_s.dir_lat = s.sy2[24];
      end

      // rx clock divider, held low while the synth is off
      next_s.ph  = synth_on ? 2'(s.ph + 2'h1) : 2'h0;
      next_s.clk = synth_on && (next_s.ph < `BDP_PH_HIGH_END);

      if (tick)
      begin
         if (slot_free && rx_sample_valid)
         begin
            word        = s.cfg.order_swap
                        ? {rx_sample_data[11:0], rx_sample_data[23:12]}
                        : rx_sample_data;
            next_s.sh   = word;
            next_s.cnt  = 2'h0;
            next_s.busy = 1'b1;
            next_s.tog  = !s.tog;
         end
         else if (s.busy && rx_path && s.cnt != last)
         begin
            word        = (last == 2'h3) ? {6'h00, s.sh[23:6]}
                                         : {12'h000, s.sh[23:12]};
            next_s.sh   = word;
            next_s.cnt  = 2'(s.cnt + 2'h1);
         end
         else
         begin
            next_s.busy = 1'b0;
            next_s.cnt  = 2'h0;
         end
         case (last)
            2'h0:    lanes = word;
            2'h3:    lanes = {18'h00000, word[5:0]};
            default: lanes = {12'h000, word[11:0]};
         endcase
         next_s.a_out = lanes[11:0];
         next_s.b_out = lanes[23:12];
         // single-beat samples toggle, multi-beat ones are high half the time
         if (!next_s.busy)
            next_s.frame = 1'b0;
         else if (!s.cfg.rx_frame_pulse)
            next_s.frame = 1'b1;
         else if (last == 2'h0)
            next_s.frame = next_s.tog;
         else
            next_s.frame = next_s.cnt <= (last >> 1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s     <= '0;
         s.cfg <= bdp_pkg::bdp_cfg_t'(`BDP_CFG_RESET);
      end
      else
         s <= next_s;
   end

   bdp_enable_state_machine u_enable_state_machine
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (ens.fsm)
   );

   bdp_tx_capture u_txcap
   (
      .pclk            (pclk),
      .presetn         (presetn),
      .ret_rise        (ret_rise),
      .ret_fall        (ret_fall),
      .frame           (s.sy2[26]),
      .pins_a          (s.sy2[11:0]),
      .pins_b          (s.sy2[23:12]),
      .cfg             (s.cfg),
      .tx_active       (tx_path),
      .tx_sample_data  (tx_sample_data),
      .tx_sample_valid (tx_sample_valid)
   );

endmodule

`default_nettype wire

// file: verif/bdp_data_port_checker.sv
// pin-level checks of the baseband data port
`timescale 1ns/1ps
`default_nettype none
module bdp_data_port_checker
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rx_sample_ready,
   input wire logic        tx_sample_valid,
   input wire logic        rx_data_clock,
   input wire logic        lvds_select,
   input wire logic        rx_synth_on,
   input wire logic        tx_synth_on,
   input wire logic        rx_chain_on,
   input wire logic        tx_chain_on,
   input wire logic [2:0]  enable_state_machine_state
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   wire logic unmap = paddr > 12'h008 || paddr[1:0] != 2'h0;
   zero_wait_a: assert property (psel |-> pready)
      else $error("pready low");
   unmapped_err_a: assert property (acc |-> pslverr == unmap)
      else $error("pslverr wrong");
   unmapped_data_a: assert property (acc && unmap |-> prdata == 32'h0)
      else $error("unmapped data");
   lvds_cfg_a: assert property (acc && pwrite && paddr == 12'h000
      |=> lvds_select == $past(pwdata[0]))
      else $error("lvds select wrong");
   state_code_a: assert property (enable_state_machine_state <= 3'h5)
      else $error("bad state code");
   wait_off_a: assert property (enable_state_machine_state == 3'h0 |-> !(rx_synth_on
      || tx_synth_on || rx_chain_on || tx_chain_on))
      else $error("on in wait");
   tx_only_a: assert property (enable_state_machine_state == 3'h2
      |-> tx_chain_on && !rx_chain_on)
      else $error("tx chains wrong");
   rx_only_a: assert property (enable_state_machine_state == 3'h3
      |-> rx_chain_on && !tx_chain_on)
      else $error("rx chains wrong");
   ready_path_a: assert property (rx_sample_ready
      |-> enable_state_machine_state inside {3'h3, 3'h4})
      else $error("ready, path off");
   sleep_clk_a: assert property (enable_state_machine_state == 3'h1 [*3]
      |-> !rx_data_clock)
      else $error("clock in sleep");
   clk_low_a: assert property ($fell(rx_data_clock) && enable_state_machine_state != 3'h1
      |=> !rx_data_clock ##1 (rx_data_clock || enable_state_machine_state == 3'h1))
      else $error("clock low wrong");
   tx_pulse_a: assert property (tx_sample_valid |=> !tx_sample_valid)
      else $error("tx valid too long");
endmodule
`default_nettype wire

// file: verif/bdp_bbp_model.sv
// baseband processor model: return clock, frame, pins, tx data
`timescale 1ns/1ps
`default_nettype none
module bdp_bbp_model
#(
   parameter int HALF_NS = 40
)
(
   output logic        tx_return_clock,
   output logic        tx_frame,
   output logic        enable_state_machine,
   output logic        direction_select_pin,
   output logic [11:0] data_port_a_in,
   output logic [11:0] data_port_b_in
);
   logic busy;
   initial
   begin
      busy = 1'b0;
      tx_return_clock = 1'b0;
      tx_frame = 1'b0;
      enable_state_machine = 1'b0;
      direction_select_pin = 1'b0;
      data_port_a_in = 12'h5a5;
      data_port_b_in = 12'ha5a;
   end
   // slower than rx clock so the 2-flop sync sees every level
   always #(HALF_NS) tx_return_clock = ~tx_return_clock;
   // released lines keep changing so stale data never matches
   always @(negedge tx_return_clock)
      if (!busy)
      begin
         data_port_a_in <= ~data_port_a_in;
         data_port_b_in <= ~data_port_b_in;
      end
   // launch on falling edge, hold two periods
   task automatic set_pins(input logic en, input logic dir);
      @(negedge tx_return_clock);
      enable_state_machine <= en;
      direction_select_pin <= dir;
      repeat (2) @(negedge tx_return_clock);
   endtask
   task automatic send2(input logic [23:0] s0, input logic [23:0] s1);
      busy = 1'b1;
      @(negedge tx_return_clock);
      tx_frame <= 1'b1;
      data_port_a_in <= s0[11:0];
      data_port_b_in <= s0[23:12];
      @(negedge tx_return_clock);
      data_port_a_in <= s1[11:0];
      data_port_b_in <= s1[23:12];
      @(negedge tx_return_clock);
      tx_frame <= 1'b0;
      busy = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: verif/bdp_data_port_bench.sv
// self-checking bench of the baseband data port
`timescale 1ns/1ps
`default_nettype none
module bdp_data_port_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, m_a, m_b;
   logic [31:0] pwdata, prdata;
   logic [23:0] rx_sample_data, tx_sample_data;
   logic        rx_sample_valid, rx_sample_ready, tx_sample_valid;
   logic        rx_data_clock, rx_frame, tx_return_clock, tx_frame;
   logic        enable_state_machine, direction_select_pin, lvds_select;
   logic        bb_synth_on, rx_synth_on, tx_synth_on;
   logic        rx_chain_on, tx_chain_on;
   logic [2:0]  enable_state_machine_state;
   logic [11:0] data_port_a_out, data_port_a_oe;
   logic [11:0] data_port_b_out, data_port_b_oe;
   int          n_mismatch, n_tests;
   wire logic [11:0] data_port_a_in =
      (data_port_a_oe & data_port_a_out) | (~data_port_a_oe & m_a);
   wire logic [11:0] data_port_b_in =
      (data_port_b_oe & data_port_b_out) | (~data_port_b_oe & m_b);
   logic [11:0] tab [10] = '{12'h055, 12'h022, 12'h033, 12'h043, 12'h000,
      12'h011, 12'h000, 12'h244, 12'h224, 12'h255};
   bdp_data_port bdp_data_port_i (.*);
   bdp_bbp_model bdp_bbp_model_i (.tx_return_clock, .tx_frame,
      .enable_state_machine, .direction_select_pin,
      .data_port_a_in(m_a), .data_port_b_in(m_b));
   always #5 pclk = ~pclk;
   task automatic final_report();
      $display("compares %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error at %0t ns: got %h want %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r, output logic er);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      apb(a, 1'b1, d, r, er);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input logic ee);
      logic [31:0] r;
      logic er;
      apb(a, 1'b0, 32'h0, r, er);
      chk(r, e);
      chk({31'h0, er}, {31'h0, ee});
   endtask
   task automatic wait_state(input logic [2:0] s);
      int n;
      n = 0;
      while (enable_state_machine_state !== s && n < 80)
      begin
         @(negedge pclk);
         n++;
      end
      chk(32'(enable_state_machine_state), 32'(s));
      @(posedge pclk);
   endtask
   function automatic logic [31:0] sts(input logic [2:0] s);
      sts = {26'h0, s == 3'h2 || s == 3'h4, s == 3'h3 || s == 3'h4,
         s != 3'h1, s};
   endfunction
   task automatic rx_one(input logic [31:0] c, input logic [23:0] d,
      input logic [11:0] a0, input logic [11:0] b0);
      wr(12'h000, c);
      rx_sample_data <= d;
      rx_sample_valid <= 1'b1;
      @(negedge pclk);
      while (rx_sample_ready !== 1'b1)
         @(negedge pclk);
      @(posedge pclk);
      rx_sample_valid <= 1'b0;
      #1;
      chk(32'(data_port_a_out), 32'(a0));
      chk(32'(data_port_a_oe), 32'hfff);
      if (!c[2])
         chk(32'(data_port_b_out), 32'(b0));
      chk({31'h0, rx_frame}, 32'h1);
      if (!c[3])
         chk({31'h0, rx_data_clock}, 32'h0);
   endtask
   task automatic expect_tx(input logic [23:0] e);
      while (tx_sample_valid !== 1'b1)
         @(negedge pclk);
      chk(32'(tx_sample_data), 32'(e));
      @(negedge pclk);
   endtask
   initial
   begin
      #200000;
      n_mismatch++;
      final_report();
   end
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, rx_sample_valid} = '0;
      {paddr, pwdata, rx_sample_data, n_mismatch, n_tests} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h000, 32'h0, 1'b0);
      rd(12'h008, 32'h8, 1'b0);
      wr(12'h000, 32'hffffffff);
      rd(12'h000, 32'h3ff, 1'b0);
      chk({31'h0, lvds_select}, 32'h1);
      rd(12'h00c, 32'h0, 1'b1);
      $display("register test done");
      foreach (tab[i])
      begin
         wr(12'h000, 32'(tab[i][11:8]));
         wr(12'h004, 32'(tab[i][7:4]));
         wait_state(tab[i][2:0]);
         rd(12'h008, sts(tab[i][2:0]), 1'b0);
      end
      $display("state command test done");
      wr(12'h000, 32'h0);
      wr(12'h004, 32'h3);
      rx_one(32'h000, 24'habc123, 12'h123, 12'habc);
      rx_one(32'h040, 24'habc123, 12'habc, 12'h123);
      rx_one(32'h00c, 24'h456789, 12'h789, 12'h0);
      repeat (2) @(posedge pclk);
      #1 chk(32'(data_port_a_out), 32'h456);
      @(posedge pclk);
      $display("rx stream test done");
      wr(12'h000, 32'h0);
      wr(12'h004, 32'h2);
      wait_state(3'h2);
      chk(32'(data_port_a_oe), 32'h0);
      fork
         bdp_bbp_model_i.send2(24'h5a5123, 24'h0f0e0d);
         begin
            expect_tx(24'h5a5123);
            expect_tx(24'h0f0e0d);
         end
      join
      @(posedge pclk);
      $display("tx capture test done");
      wr(12'h000, 32'h080);
      wr(12'h004, 32'h5);
      wait_state(3'h5);
      bdp_bbp_model_i.set_pins(1'b1, 1'b1);
      wait_state(3'h2);
      bdp_bbp_model_i.set_pins(1'b1, 1'b0);
      wait_state(3'h3);
      bdp_bbp_model_i.set_pins(1'b0, 1'b0);
      wait_state(3'h5);
      wr(12'h004, 32'h2);
      repeat (3) @(posedge pclk);
      chk(32'(enable_state_machine_state), 32'h5);
      wr(12'h000, 32'h180);
      bdp_bbp_model_i.set_pins(1'b1, 1'b1);
      bdp_bbp_model_i.set_pins(1'b0, 1'b1);
      wait_state(3'h2);
      bdp_bbp_model_i.set_pins(1'b1, 1'b1);
      bdp_bbp_model_i.set_pins(1'b0, 1'b1);
      wait_state(3'h5);
      $display("pin control test done");
      @(posedge pclk);
      wr(12'h000, 32'h282);
      wr(12'h004, 32'h4);
      wait_state(3'h4);
      bdp_bbp_model_i.set_pins(1'b1, 1'b0);
      rd(12'h008, 32'h1c, 1'b0);
      bdp_bbp_model_i.set_pins(1'b0, 1'b1);
      rd(12'h008, 32'h2c, 1'b0);
      bdp_bbp_model_i.set_pins(1'b0, 1'b0);
      @(posedge pclk);
      wr(12'h004, 32'h5);
      wait_state(3'h5);
      $display("remap test done");
      final_report();
   end
endmodule
bind bdp_data_port bdp_data_port_checker bdp_data_port_checker_i (.*);
`default_nettype wire
